// file: design/pnt_neighbour_table.sv
/*
 Neighbour link-parameter table: one entry per unicast peer, refreshed
 on tone map responses, aged once a minute, evicted by least lifetime.
 Assumes request strobes from MAC logic on mclk, one cycle each.
*/
`timescale 1ns/1ps
`default_nettype none
module pnt_neighbour_table
   import pnt_pkg::*;
#(
   parameter int ENTRIES = 8,
   parameter longint MINUTE_CYCLES = PNT_MINUTE_CYCLES
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wide_bandplan,
   input wire logic [7:0] lifetime_reload_value,
   input wire logic [7:0] lifetime_default_value,
   input wire logic rsp_valid,
   input wire logic [PNT_ADDR_W-1:0] rsp_address,
   input wire pnt_params_type rsp_params,
   input wire logic fail_valid,
   input wire logic [PNT_ADDR_W-1:0] fail_address,
   input wire logic tx_query_valid,
   input wire logic [PNT_ADDR_W-1:0] tx_query_address,
   output logic tone_map_request,
   output logic [PNT_ADDR_W-1:0] tone_map_request_address,
   input wire logic [PNT_ADDR_W-1:0] adp_rd_address,
   output logic adp_rd_hit,
   output pnt_entry_type adp_rd_entry,
   input wire logic [PNT_ADDR_W-1:0] mac_rd_address,
   output logic mac_rd_hit,
   output pnt_entry_type mac_rd_entry,
   input wire logic [PNT_ADDR_W-1:0] phy_rd_address,
   output logic phy_rd_hit,
   output pnt_entry_type phy_rd_entry,
   output logic [$clog2(ENTRIES+1)-1:0] entry_count
);
   localparam int IDX_W = $clog2(ENTRIES);
   localparam int CNT_W = $clog2(ENTRIES+1);

   typedef struct packed {
      logic hit;
      logic [IDX_W-1:0] idx;
   } pnt_lookup_type;

   pnt_entry_type table_reg [ENTRIES];
   logic [ENTRIES-1:0] valid_vec;
   logic [ENTRIES*8-1:0] life_vec;
   logic [IDX_W-1:0] victim;
   logic minute_tick;
   logic wide_reg;
   logic [CNT_W-1:0] count_next;
   pnt_lookup_type rsp_look;
   pnt_lookup_type fail_look;
   pnt_lookup_type tx_look;
   pnt_lookup_type adp_look;
   pnt_lookup_type mac_look;
   pnt_lookup_type phy_look;
   pnt_params_type rsp_clean;

   // Address match is shared by every lookup port.
   function automatic pnt_lookup_type lookup(
      input logic [PNT_ADDR_W-1:0] addr,
      input logic [ENTRIES-1:0] vld,
      input logic [ENTRIES*PNT_ADDR_W-1:0] addrs);
      pnt_lookup_type r;
      r.hit = 1'b0;
      r.idx = '0;
      for (int i = 0; i < ENTRIES; i++)
      begin
         if (!r.hit && vld[i] && addrs[i*PNT_ADDR_W +: PNT_ADDR_W] == addr)
         begin
            r.hit = 1'b1;
            r.idx = IDX_W'(i);
         end
      end
      return r;
   endfunction

   logic [ENTRIES*PNT_ADDR_W-1:0] addr_vec;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++)
      begin : g_flat
         assign valid_vec[g] = table_reg[g].valid;
         assign life_vec[g*8 +: 8] = table_reg[g].link_param_lifetime;
         assign addr_vec[g*PNT_ADDR_W +: PNT_ADDR_W] =
            table_reg[g].params.short_address;
      end
   endgenerate

   always_comb
   begin
      rsp_look = lookup(rsp_address, valid_vec, addr_vec);
      fail_look = lookup(fail_address, valid_vec, addr_vec);
      tx_look = lookup(tx_query_address, valid_vec, addr_vec);
      adp_look = lookup(adp_rd_address, valid_vec, addr_vec);
      mac_look = lookup(mac_rd_address, valid_vec, addr_vec);
      phy_look = lookup(phy_rd_address, valid_vec, addr_vec);
   end

   pnt_victim_select #(
      .ENTRIES(ENTRIES),
      .IDX_W(IDX_W)
   ) u_victim (
      .valid(valid_vec),
      .lifetimes(life_vec),
      .victim(victim)
   );

   pnt_minute_tick #(
      .MINUTE_CYCLES(MINUTE_CYCLES)
   ) u_tick (
      .mclk(mclk),
      .resetn(resetn),
      .tick(minute_tick)
   );

   // Layout follows wide_bandplan until the first entry is counted, then holds until reset;
   // changing it live would mix layouts between entries.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         wide_reg <= 1'b0;
      else if (entry_count == '0)
         wide_reg <= wide_bandplan;
   end

   // Incoming parameters are trimmed to the chosen layout.
   always_comb
   begin
      rsp_clean = rsp_params;
      if (!wide_reg)
      begin
         rsp_clean.subband_usage_mask =
            {18'h0_0000, rsp_params.subband_usage_mask[PNT_NB_MASK_W-1:0]};
         rsp_clean.constellation_select =
            rsp_params.constellation_select & PNT_NB_CONST_MASK;
         rsp_clean.per_group_gain_adjust =
            {24'h00_0000, rsp_params.per_group_gain_adjust[PNT_NB_ADJ_W-1:0]};
      end
      else if (rsp_params.constellation_select > PNT_CONST_16QAM)
         rsp_clean.constellation_select = PNT_CONST_ROBUST;
      if (rsp_clean.constellation_select == PNT_CONST_16QAM &&
          rsp_params.payload_modulation != PNT_MOD_COH)
         rsp_clean.constellation_select = PNT_CONST_8PSK;
      rsp_clean.short_address = rsp_address;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < ENTRIES; i++)
            table_reg[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < ENTRIES; i++)
         begin
            // Aging first so a same-cycle reload or failure wins.
            if (minute_tick && table_reg[i].valid &&
                table_reg[i].link_param_lifetime != 8'h00)
               table_reg[i].link_param_lifetime <=
                  table_reg[i].link_param_lifetime - 8'h01;
            if (fail_valid && fail_look.hit && fail_look.idx == IDX_W'(i))
               table_reg[i].link_param_lifetime <= 8'h00;
         end
         if (rsp_valid)
         begin
            if (rsp_look.hit)
            begin
               table_reg[rsp_look.idx].params <= rsp_clean;
               table_reg[rsp_look.idx].link_param_lifetime <=
                  lifetime_reload_value;
            end
            else
            begin
               table_reg[victim].params <= rsp_clean;
               table_reg[victim].valid <= 1'b1;
               table_reg[victim].link_param_lifetime <=
                  lifetime_default_value;
            end
         end
      end
   end

   always_comb
   begin
      count_next = '0;
      for (int i = 0; i < ENTRIES; i++)
         count_next = count_next + CNT_W'(valid_vec[i]);
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         entry_count <= '0;
      else
         entry_count <= count_next;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tone_map_request <= 1'b0;
         tone_map_request_address <= 16'h0000;
      end
      else
      begin
         // A peer not in the table also has no valid parameters.
         tone_map_request <= tx_query_valid && (!tx_look.hit ||
            table_reg[tx_look.idx].link_param_lifetime == 8'h00);
         if (tx_query_valid)
            tone_map_request_address <= tx_query_address;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         adp_rd_hit <= 1'b0;
         mac_rd_hit <= 1'b0;
         phy_rd_hit <= 1'b0;
         adp_rd_entry <= '0;
         mac_rd_entry <= '0;
         phy_rd_entry <= '0;
      end
      else
      begin
         adp_rd_hit <= adp_look.hit;
         mac_rd_hit <= mac_look.hit;
         phy_rd_hit <= phy_look.hit;
         adp_rd_entry <= adp_look.hit ? table_reg[adp_look.idx] : '0;
         mac_rd_entry <= mac_look.hit ? table_reg[mac_look.idx] : '0;
         phy_rd_entry <= phy_look.hit ? table_reg[phy_look.idx] : '0;
      end
   end

   // Per-entry checks: layout width limits, constellation codes, lifetime aging, victim choice.
   generate
      for (g = 0; g < ENTRIES; g++)
      begin : g_chk
         chk_narrow_mask_width: assert property (@(posedge mclk)
            disable iff (!resetn) (table_reg[g].valid && !wide_reg) |->
            table_reg[g].params.subband_usage_mask[23:6] == 18'h0_0000 &&
            table_reg[g].params.constellation_select[2] == 1'b0)
            else $error("narrow entry exceeds layout");
         chk_qam_needs_coherent: assert property (@(posedge mclk)
            disable iff (!resetn)
            table_reg[g].params.constellation_select == PNT_CONST_16QAM
            |-> table_reg[g].params.payload_modulation == PNT_MOD_COH)
            else $error("16-QAM stored without coherent");
         chk_wide_no_reserved: assert property (@(posedge mclk)
            disable iff (!resetn)
            table_reg[g].params.constellation_select <= PNT_CONST_16QAM)
            else $error("reserved constellation stored");
         chk_lifetime_aging: assert property (@(posedge mclk)
            disable iff (!resetn)
            (minute_tick && table_reg[g].valid && !rsp_valid &&
             !fail_valid && table_reg[g].link_param_lifetime != 8'h00)
            |=> table_reg[g].link_param_lifetime ==
                $past(table_reg[g].link_param_lifetime) - 8'h01)
            else $error("lifetime did not age");
         chk_victim_minimum: assert property (@(posedge mclk)
            disable iff (!resetn) (&valid_vec) |->
            life_vec[victim*8 +: 8] <= table_reg[g].link_param_lifetime)
            else $error("victim lifetime above another entry");
      end
   endgenerate

   chk_refresh_reload: assert property (@(posedge mclk)
      disable iff (!resetn) (rsp_valid && rsp_look.hit) |=>
      table_reg[$past(rsp_look.idx)].link_param_lifetime ==
      $past(lifetime_reload_value))
      else $error("refresh did not reload lifetime");
   chk_create_default: assert property (@(posedge mclk)
      disable iff (!resetn) (rsp_valid && !rsp_look.hit) |=>
      table_reg[$past(victim)].valid &&
      table_reg[$past(victim)].link_param_lifetime ==
      $past(lifetime_default_value) &&
      table_reg[$past(victim)].params.short_address == $past(rsp_address))
      else $error("create did not store entry");
   chk_fail_zeroes: assert property (@(posedge mclk)
      disable iff (!resetn) (fail_valid && fail_look.hit && !rsp_valid) |=>
      table_reg[$past(fail_look.idx)].link_param_lifetime == 8'h00)
      else $error("failure did not zero lifetime");
   chk_evict_smallest: assert property (@(posedge mclk)
      disable iff (!resetn) (&valid_vec) |->
      life_vec[victim*8 +: 8] <= life_vec[0 +: 8])
      else $error("victim not smallest lifetime");
   chk_request_zero: assert property (@(posedge mclk)
      disable iff (!resetn) (tx_query_valid && tx_look.hit &&
      table_reg[tx_look.idx].link_param_lifetime != 8'h00)
      |=> !tone_map_request)
      else $error("request raised for live peer");
   chk_read_hit: assert property (@(posedge mclk)
      disable iff (!resetn) mac_look.hit |=>
      mac_rd_hit && mac_rd_entry.valid)
      else $error("mac read missed entry");

   // Slot that a response lands in, for the storage checks.
   logic [IDX_W-1:0] write_idx;
   assign write_idx = rsp_look.hit ? rsp_look.idx : victim;

   chk_fields_kept: assert property (@(posedge mclk)
      disable iff (!resetn) rsp_valid |=>
      table_reg[$past(write_idx)].params.payload_modulation ==
      $past(rsp_params.payload_modulation) &&
      table_reg[$past(write_idx)].params.transmit_amplification ==
      $past(rsp_params.transmit_amplification) &&
      table_reg[$past(write_idx)].params.gain_step_size ==
      $past(rsp_params.gain_step_size) &&
      table_reg[$past(write_idx)].params.reverse_link_quality ==
      $past(rsp_params.reverse_link_quality) &&
      table_reg[$past(write_idx)].params.mains_phase_offset ==
      $past(rsp_params.mains_phase_offset))
      else $error("stored fields differ from response");
   chk_wide_kept: assert property (@(posedge mclk)
      disable iff (!resetn) (rsp_valid && wide_reg) |=>
      table_reg[$past(write_idx)].params.subband_usage_mask ==
      $past(rsp_params.subband_usage_mask) &&
      table_reg[$past(write_idx)].params.per_group_gain_adjust ==
      $past(rsp_params.per_group_gain_adjust))
      else $error("wide mask or gains not stored");
   chk_adp_read: assert property (@(posedge mclk)
      disable iff (!resetn) adp_look.hit |=>
      adp_rd_hit && adp_rd_entry.valid)
      else $error("adp read missed entry");
   chk_phy_read: assert property (@(posedge mclk)
      disable iff (!resetn) phy_look.hit |=>
      phy_rd_hit && phy_rd_entry.valid)
      else $error("phy read missed entry");
endmodule // pnt_neighbour_table
`default_nettype wire

// file: design/pnt_pkg.sv
/*
 Package for the neighbour link-parameter table: field widths, entry
 layout, constellation codes, table timing constants.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pnt_pkg;
   localparam int PNT_ADDR_W = 16;
   localparam int PNT_MASK_W = 24;
   localparam int PNT_ADJ_W = 48;
   localparam int PNT_NB_MASK_W = 6;
   localparam int PNT_NB_ADJ_W = 24;
   localparam int PNT_NB_GROUPS = 6;
   localparam int PNT_WB_GROUPS = 24;
   localparam logic [2:0] PNT_CONST_ROBUST = 3'h0;
   localparam logic [2:0] PNT_CONST_BPSK = 3'h1;
   localparam logic [2:0] PNT_CONST_QPSK = 3'h2;
   localparam logic [2:0] PNT_CONST_8PSK = 3'h3;
   localparam logic [2:0] PNT_CONST_16QAM = 3'h4;
   localparam logic [2:0] PNT_NB_CONST_MASK = 3'h3;
   localparam logic PNT_MOD_DIFF = 1'b0;
   localparam logic PNT_MOD_COH = 1'b1;
   localparam logic PNT_STEP_6DB = 1'b0;
   localparam logic PNT_STEP_3DB = 1'b1;
   localparam logic [7:0] PNT_LIFETIME_DEFAULT = 8'h0F;
   localparam logic [7:0] PNT_LIFETIME_RESET = 8'h00;
   localparam int PNT_MINUTE_S = 60;
   localparam longint PNT_CLK_HZ = 250000000;
   localparam longint PNT_MINUTE_CYCLES = PNT_MINUTE_S * PNT_CLK_HZ;

   // Wide fields hold both layouts; narrow layout keeps its data low.
   typedef struct packed {
      logic [PNT_ADDR_W-1:0] short_address;
      logic payload_modulation;
      logic [PNT_MASK_W-1:0] subband_usage_mask;
      logic [2:0] constellation_select;
      logic [3:0] transmit_amplification;
      logic gain_step_size;
      logic [PNT_ADJ_W-1:0] per_group_gain_adjust;
      logic [7:0] reverse_link_quality;
      logic [2:0] mains_phase_offset;
   } pnt_params_type;

   typedef struct packed {
      pnt_params_type params;
      logic [7:0] link_param_lifetime;
      logic valid;
   } pnt_entry_type;
endpackage

// file: design/pnt_minute_tick.sv
/*
 Minute tick generator for the lifetime counters.
 Assumes a free running mclk; the period is a parameter for simulation.
*/
`timescale 1ns/1ps
`default_nettype none
module pnt_minute_tick
   import pnt_pkg::*;
#(
   parameter longint MINUTE_CYCLES = PNT_MINUTE_CYCLES
)
(
   input wire logic mclk,
   input wire logic resetn,
   output logic tick
);
   logic [39:0] count_reg;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         count_reg <= 40'h00_0000_0000;
         tick <= 1'b0;
      end
      else if (count_reg == 40'(MINUTE_CYCLES - 1))
      begin
         count_reg <= 40'h00_0000_0000;
         tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 40'h00_0000_0001;
         tick <= 1'b0;
      end
   end
endmodule // pnt_minute_tick
`default_nettype wire

// file: design/pnt_victim_select.sv
/*
 Chooses the slot for a new entry: a free slot if any, else the valid
 entry with the smallest remaining lifetime, lowest index on a tie.
 Assumes combinational use inside the table.
*/
`timescale 1ns/1ps
`default_nettype none
module pnt_victim_select
   import pnt_pkg::*;
#(
   parameter int ENTRIES = 8,
   parameter int IDX_W = 3
)
(
   input wire logic [ENTRIES-1:0] valid,
   input wire logic [ENTRIES*8-1:0] lifetimes,
   output logic [IDX_W-1:0] victim
);
   always_comb
   begin
      logic found;
      logic [7:0] best;
      found = 1'b0;
      best = 8'hFF;
      victim = '0;
      for (int i = 0; i < ENTRIES; i++)
      begin
         if (!found && !valid[i])
         begin
            found = 1'b1;
            victim = IDX_W'(i);
         end
      end
      if (!found)
      begin
         for (int i = ENTRIES - 1; i >= 0; i--)
         begin
            if (lifetimes[i*8 +: 8] <= best)
            begin
               best = lifetimes[i*8 +: 8];
               victim = IDX_W'(i);
            end
         end
      end
   end
endmodule // pnt_victim_select
`default_nettype wire

// file: bench/pnt_mac_model.sv
/*
 MAC side model: issues tone map responses, failures and send queries.
 Assumes the table samples its strobes on the rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pnt_mac_model
   import pnt_pkg::*;
(
   input wire logic mclk,
   output logic rsp_valid,
   output logic [PNT_ADDR_W-1:0] rsp_address,
   output pnt_params_type rsp_params,
   output logic fail_valid,
   output logic [PNT_ADDR_W-1:0] fail_address,
   output logic tx_query_valid,
   output logic [PNT_ADDR_W-1:0] tx_query_address,
   input wire logic tone_map_request,
   input wire logic [PNT_ADDR_W-1:0] tone_map_request_address
);
   initial
   begin
      rsp_valid = 1'b0;
      rsp_address = 16'h0000;
      rsp_params = '0;
      fail_valid = 1'b0;
      fail_address = 16'h0000;
      tx_query_valid = 1'b0;
      tx_query_address = 16'h0000;
   end

   // Released lines are inverted so stale data can never pass for valid.
   task automatic respond(input logic [15:0] a, input pnt_params_type p);
      @(posedge mclk);
      #1;
      rsp_valid = 1'b1;
      rsp_address = a;
      rsp_params = p;
      @(posedge mclk);
      #1;
      rsp_valid = 1'b0;
      rsp_address = ~a;
      rsp_params = ~p;
   endtask

   task automatic fail(input logic [15:0] a);
      @(posedge mclk);
      #1;
      fail_valid = 1'b1;
      fail_address = a;
      @(posedge mclk);
      #1;
      fail_valid = 1'b0;
      fail_address = ~a;
   endtask

   task automatic query(input logic [15:0] a, output logic r,
      output logic [15:0] ra, output logic r2);
      @(posedge mclk);
      #1;
      tx_query_valid = 1'b1;
      tx_query_address = a;
      @(posedge mclk);
      #1;
      tx_query_valid = 1'b0;
      tx_query_address = ~a;
      r = tone_map_request;
      ra = tone_map_request_address;
      @(posedge mclk);
      #1;
      r2 = tone_map_request;
   endtask
endmodule // pnt_mac_model
`default_nettype wire

// file: bench/plc_neighbour_table_tb.sv
/*
 Self-checking bench for the neighbour table with a MAC side model.
 Assumes pnt_pkg, the design files and the model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module plc_neighbour_table_tb;
   import pnt_pkg::*;
   // A short minute keeps ageing visible within a few thousand cycles.
   localparam int MC = 3000;
   localparam logic [15:0] A = 16'h0A01;
   logic mclk;
   logic resetn;
   logic wide;
   logic [7:0] rld;
   logic [7:0] dflt;
   logic rv;
   logic [15:0] ra;
   pnt_params_type rp;
   logic fv;
   logic [15:0] fa;
   logic qv;
   logic [15:0] qa;
   logic tmr;
   logic [15:0] tma;
   logic [15:0] rda;
   wire logic [2:0] hit;
   pnt_entry_type e0;
   pnt_entry_type e1;
   pnt_entry_type e2;
   logic [2:0] cnt;
   int n_fail;
   int comparisons;
   logic [7:0] lt [4] = '{8'h30, 8'h10, 8'h20, 8'h50};
   logic [7:0] wk [4] = '{8'h84, 8'h04, 8'h8D, 8'h82};

   pnt_mac_model i_mac (.mclk(mclk), .rsp_valid(rv), .rsp_address(ra),
      .rsp_params(rp), .fail_valid(fv), .fail_address(fa),
      .tx_query_valid(qv), .tx_query_address(qa),
      .tone_map_request(tmr), .tone_map_request_address(tma));

   pnt_neighbour_table #(.ENTRIES(4), .MINUTE_CYCLES(MC)) i_dut (
      .mclk(mclk), .resetn(resetn), .wide_bandplan(wide),
      .lifetime_reload_value(rld), .lifetime_default_value(dflt),
      .rsp_valid(rv), .rsp_address(ra), .rsp_params(rp),
      .fail_valid(fv), .fail_address(fa),
      .tx_query_valid(qv), .tx_query_address(qa),
      .tone_map_request(tmr), .tone_map_request_address(tma),
      .adp_rd_address(rda), .adp_rd_hit(hit[0]), .adp_rd_entry(e0),
      .mac_rd_address(rda), .mac_rd_hit(hit[1]), .mac_rd_entry(e1),
      .phy_rd_address(rda), .phy_rd_hit(hit[2]), .phy_rd_entry(e2),
      .entry_count(cnt));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp_v(string n, logic [15:0] x, logic [15:0] g);
      comparisons++;
      if (g !== x)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", n, x, g);
      end
   endtask

   task automatic cmp_e(string n, pnt_entry_type x, pnt_entry_type g);
      comparisons++;
      if (g !== x)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", n, x, g);
      end
   endtask

   function automatic pnt_params_type mk(logic [15:0] a, logic [7:0] k);
      pnt_params_type p;
      p.short_address = a;
      p.payload_modulation = k[7];
      p.subband_usage_mask = {k, ~k, k};
      p.constellation_select = k[2:0];
      p.transmit_amplification = k[3:0];
      p.gain_step_size = k[1];
      p.per_group_gain_adjust = {3{k, ~k}};
      p.reverse_link_quality = ~k;
      p.mains_phase_offset = k[6:4];
      return p;
   endfunction

   // Expected entry: narrow data sits in the low bits, wide codes fixed up.
   function automatic pnt_entry_type ent(logic [15:0] a, logic [7:0] k,
      logic w, logic [7:0] l);
      pnt_entry_type e;
      pnt_params_type p;
      p = mk(a, k);
      if (!w)
      begin
         p.subband_usage_mask &= 24'h00_003F;
         p.per_group_gain_adjust &= 48'h0000_00FF_FFFF;
         p.constellation_select &= PNT_NB_CONST_MASK;
      end
      else if (p.constellation_select > PNT_CONST_16QAM)
         p.constellation_select = PNT_CONST_ROBUST;
      else if (p.constellation_select == PNT_CONST_16QAM &&
         p.payload_modulation == PNT_MOD_DIFF)
         p.constellation_select = PNT_CONST_8PSK;
      e.params = p;
      e.link_param_lifetime = l;
      e.valid = 1'b1;
      return e;
   endfunction

   task automatic rd(logic [15:0] a, pnt_entry_type x);
      @(posedge mclk);
      #1;
      rda = a;
      repeat (2) @(posedge mclk);
      #1;
      cmp_v("adp hit", 16'(x.valid), 16'(hit[0]));
      cmp_v("mac hit", 16'(x.valid), 16'(hit[1]));
      cmp_v("phy hit", 16'(x.valid), 16'(hit[2]));
      cmp_e("adp entry", x, e0);
      cmp_e("mac entry", x, e1);
      cmp_e("phy entry", x, e2);
   endtask

   task automatic q(logic [15:0] a, logic x);
      logic r;
      logic [15:0] ga;
      logic r2;
      i_mac.query(a, r, ga, r2);
      cmp_v("request", 16'(x), 16'(r));
      if (x)
         cmp_v("request address", a, ga);
      cmp_v("request after pulse", 16'h0000, 16'(r2));
   endtask

   task automatic rst(logic w);
      resetn = 1'b0;
      wide = w;
      repeat (8) @(posedge mclk);
      #1;
      resetn = 1'b1;
   endtask

   initial
   begin
      repeat (30000) @(posedge mclk);
      n_fail++;
      $display("unexpected run length: expected end, seen timeout");
      end_sim();
   end

   initial
   begin
      n_fail = 0;
      comparisons = 0;
      rda = 16'h0000;
      rld = 8'h40;
      dflt = 8'h0F;
      rst(1'b0);
      rd(A, '0);
      cmp_v("count", 16'h0000, 16'(cnt));
      i_mac.respond(A, mk(A, 8'hF7));
      rd(A, ent(A, 8'hF7, 1'b0, 8'h0F));
      i_mac.respond(A, mk(A, 8'h2C));
      rd(A, ent(A, 8'h2C, 1'b0, 8'h40));
      cmp_v("count", 16'h0001, 16'(cnt));
      q(A, 1'b0);
      i_mac.fail(16'h0B07);
      i_mac.fail(A);
      rd(A, ent(A, 8'h2C, 1'b0, 8'h00));
      cmp_v("count", 16'h0001, 16'(cnt));
      q(A, 1'b1);
      q(16'h0B07, 1'b1);
      $display("test refresh and failure done");
      i_mac.respond(A, mk(A, 8'h2C));
      foreach (lt[i])
      begin
         logic [15:0] pa;
         pa = 16'h0C00 + 16'(i);
         dflt = lt[i];
         i_mac.respond(pa, mk(pa, 8'h31));
      end
      rd(16'h0C01, '0);
      rd(16'h0C03, ent(16'h0C03, 8'h31, 1'b0, 8'h50));
      rd(A, ent(A, 8'h2C, 1'b0, 8'h40));
      cmp_v("count", 16'h0004, 16'(cnt));
      $display("test eviction done");
      rst(1'b1);
      foreach (wk[i])
      begin
         logic [15:0] pa;
         pa = 16'h0D00 + 16'(i);
         i_mac.respond(pa, mk(pa, wk[i]));
         rd(pa, ent(pa, wk[i], 1'b1, dflt));
      end
      @(posedge mclk);
      #1;
      wide = 1'b0;
      i_mac.respond(16'h0D09, mk(16'h0D09, 8'hF7));
      rd(16'h0D09, ent(16'h0D09, 8'hF7, 1'b1, dflt));
      $display("test wide layout done");
      rst(1'b0);
      dflt = 8'h02;
      i_mac.respond(A, mk(A, 8'h55));
      repeat (MC + MC / 2) @(posedge mclk);
      rd(A, ent(A, 8'h55, 1'b0, 8'h01));
      repeat (2 * MC) @(posedge mclk);
      rd(A, ent(A, 8'h55, 1'b0, 8'h00));
      q(A, 1'b1);
      $display("test ageing done");
      end_sim();
   end
endmodule // plc_neighbour_table_tb
`default_nettype wire
